// ===== common/rwic_pkg.sv
package rwic_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WDOG_TICK_NS = 31250000;
    localparam int unsigned WDOG_TICK_CYCLES = WDOG_TICK_NS / CLK_PERIOD_NS;

    localparam int unsigned ADDR_W = 20;
    localparam int unsigned DATA_W = 32;

    // register indices; the byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_FLAGS = 20'h1fff0;
    localparam logic [ADDR_W-1:0] IDX_MASK = 20'h1fff1;
    localparam logic [ADDR_W-1:0] IDX_INT_CTRL = 20'h1fff6;
    localparam logic [ADDR_W-1:0] IDX_WDOG_CTRL = 20'h1fff7;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_INT_CTRL = {IDX_INT_CTRL[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_WDOG_CTRL = {IDX_WDOG_CTRL[ADDR_W-3:0], 2'b00};

    // interrupt_control layout, msb first
    typedef struct packed {
        logic watchdog_irq_enable;
        logic alarm_irq_enable;
        logic powerfail_irq_enable;
        logic backup_alarm_enable;
        logic irq_active_high;
        logic irq_pulse_mode;
        logic [1:0] rsvd;
    } rwic_intctl_t;

    // watchdog_control layout, msb first
    typedef struct packed {
        logic watchdog_restart_strobe;
        logic timeout_write_lock;
        logic [5:0] watchdog_timeout_field;
    } rwic_wdctl_t;

    // event flags, also the layout of the flag and mask registers
    typedef struct packed {
        logic watchdog_expired_flag;
        logic alarm_match_flag;
        logic powerfail_flag;
    } rwic_evt_t;

    localparam rwic_intctl_t INTCTL_RST = 8'h00;
    localparam rwic_wdctl_t WDCTL_RST = 8'h00;
    localparam rwic_evt_t FLAGS_RST = 3'h0;
    localparam rwic_evt_t MASK_RST = 3'h7;

    typedef enum logic [1:0] {
        RWIC_BUS_IDLE = 2'b01,
        RWIC_BUS_ACK = 2'b10
    } rwic_bus_st_t;

    typedef enum logic [1:0] {
        RWIC_WD_OFF = 2'b01,
        RWIC_WD_RUN = 2'b10
    } rwic_wd_st_t;

endpackage

// ===== hw/rwic_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module rwic_tick_div #(
    parameter int unsigned CYCLES = 3125000
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clear,
    output logic tick
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic tick_q;
    wire logic wrap = (cnt_q == LAST);

    // clearing realigns the tick phase with a watchdog restart
    always_ff @(posedge mclk) begin
        if (!rst_b || clear) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            tick_q <= wrap;
        end
    end

    assign tick = tick_q;
endmodule
`default_nettype wire

// ===== hw/rwic_top.sv
`timescale 1ns/1ps
`default_nettype none
module rwic_top #(
    parameter int unsigned TICK_CYCLES = rwic_pkg::WDOG_TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rwic_pkg::ADDR_W-1:0] paddr,
    input wire logic [rwic_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [rwic_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alarm_match,
    input wire logic power_fail,
    output logic irq,
    output logic irq_pin_o,
    output logic irq_pin_oe
);
    import rwic_pkg::*;

    // bus state
    rwic_bus_st_t bus_st_q;
    logic [DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // software visible state
    rwic_intctl_t intctl_q;
    rwic_wdctl_t wdctl_q;
    rwic_evt_t flags_q;
    rwic_evt_t flags_d;
    rwic_evt_t mask_q;

    // interrupt output state
    logic irq_q;
    logic irq_pin_o_q;
    logic irq_pin_oe_q;

    // watchdog wiring
    logic wd_tick;
    logic wd_expire;
    logic [5:0] wd_count;

    // address decode
    wire logic sel_flags = (paddr == ADDR_FLAGS);
    wire logic sel_mask = (paddr == ADDR_MASK);
    wire logic sel_intctl = (paddr == ADDR_INT_CTRL);
    wire logic sel_wdctl = (paddr == ADDR_WDOG_CTRL);
    wire logic mapped = sel_flags | sel_mask | sel_intctl | sel_wdctl;

    // phases of a transfer
    wire logic setup_ph = psel && !penable;
    wire logic commit = psel && penable && pready_q && (bus_st_q == RWIC_BUS_ACK);
    wire logic wr_ok = commit && pwrite && mapped && pstrb[0];
    wire logic [7:0] wbyte = pwdata[7:0];

    // write strobes per register
    wire logic wr_flags = wr_ok && sel_flags;
    wire logic wr_mask = wr_ok && sel_mask;
    wire logic wr_intctl = wr_ok && sel_intctl;
    wire logic wr_wdctl = wr_ok && sel_wdctl;

    // incoming control words
    wire rwic_intctl_t intctl_w = rwic_intctl_t'(wbyte);
    wire rwic_wdctl_t wdctl_w = rwic_wdctl_t'(wbyte);

    // the lock bit of the written word guards the field, so a strobe
    // write with the lock set leaves the period untouched
    wire logic timeout_wr = wr_wdctl && !wdctl_w.timeout_write_lock;
    wire logic strobe_wr = wr_wdctl && wdctl_w.watchdog_restart_strobe;

    // a new period also restarts the count from zero
    wire logic wd_restart = strobe_wr || timeout_wr;

    // read views
    wire rwic_intctl_t intctl_rd = '{
        watchdog_irq_enable: intctl_q.watchdog_irq_enable,
        alarm_irq_enable: intctl_q.alarm_irq_enable,
        powerfail_irq_enable: intctl_q.powerfail_irq_enable,
        backup_alarm_enable: intctl_q.backup_alarm_enable,
        irq_active_high: intctl_q.irq_active_high,
        irq_pulse_mode: intctl_q.irq_pulse_mode,
        rsvd: 2'b00
    };
    wire rwic_wdctl_t wdctl_rd = '{
        watchdog_restart_strobe: 1'b0,
        timeout_write_lock: wdctl_q.timeout_write_lock,
        watchdog_timeout_field: wdctl_q.watchdog_timeout_field
    };

    // flag register also shows the running watchdog count
    wire logic [DATA_W-1:0] flags_view = {16'h0000, 2'b00, wd_count, 5'h00, flags_q};
    wire logic [DATA_W-1:0] mask_view = {29'h00000000, mask_q};
    wire logic [DATA_W-1:0] intctl_view = {24'h000000, intctl_rd};
    wire logic [DATA_W-1:0] wdctl_view = {24'h000000, wdctl_rd};

    wire logic [DATA_W-1:0] rd_mux =
        sel_flags ? flags_view :
        sel_mask ? mask_view :
        sel_intctl ? intctl_view :
        sel_wdctl ? wdctl_view :
        32'h00000000;

    // event sources
    wire rwic_evt_t evt_set = '{
        watchdog_expired_flag: wd_expire,
        alarm_match_flag: alarm_match,
        powerfail_flag: power_fail
    };
    wire rwic_evt_t evt_clr = wr_flags ? rwic_evt_t'(wbyte[2:0]) : 3'h0;

    // enables per source, same layout as the flags
    wire rwic_evt_t evt_en = '{
        watchdog_expired_flag: intctl_q.watchdog_irq_enable,
        alarm_match_flag: intctl_q.alarm_irq_enable,
        powerfail_flag: intctl_q.powerfail_irq_enable
    };

    // a disabled source still raises its flag, it only stays off irq and the pin
    wire rwic_evt_t evt_live = flags_q & evt_en & mask_q;
    wire logic irq_wd = evt_live.watchdog_expired_flag;
    wire logic irq_al = evt_live.alarm_match_flag;
    wire logic irq_pf = evt_live.powerfail_flag;
    wire logic irq_any = irq_wd | irq_al | irq_pf;

    // pin shape
    wire logic pin_o_d = intctl_q.irq_active_high ? irq_any : 1'b0;
    wire logic pin_oe_d = intctl_q.irq_active_high ? 1'b1 : irq_any;

    rwic_tick_div #(
        .CYCLES(TICK_CYCLES)
    ) u_div (
        .mclk(mclk),
        .rst_b(rst_b),
        .clear(wd_restart),
        .tick(wd_tick)
    );

    rwic_wdog u_wdog (
        .mclk(mclk),
        .rst_b(rst_b),
        .tick(wd_tick),
        .restart(wd_restart),
        .timeout(wdctl_q.watchdog_timeout_field),
        .expire(wd_expire),
        .count(wd_count)
    );

    // flags: a new event wins over a clear in the same cycle
    always_comb begin
        flags_d = (flags_q & ~evt_clr) | evt_set;
    end

    // apb slave: one setup, one access cycle, zero extra wait states
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bus_st_q <= RWIC_BUS_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            case (bus_st_q)
                RWIC_BUS_IDLE: begin
                    if (setup_ph) begin
                        bus_st_q <= RWIC_BUS_ACK;
                        pready_q <= 1'b1;
                        pslverr_q <= !mapped;
                        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
                    end
                end
                RWIC_BUS_ACK: begin
                    bus_st_q <= RWIC_BUS_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                end
                default: begin
                    bus_st_q <= RWIC_BUS_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                end
            endcase
        end
    end

    // interrupt control; the reserved pair never stores a one
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            intctl_q <= INTCTL_RST;
        end else if (wr_intctl) begin
            intctl_q <= {intctl_w[7:2], 2'b00};
        end
    end

    // watchdog control; the strobe is never stored
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wdctl_q <= WDCTL_RST;
        end else if (wr_wdctl) begin
            wdctl_q.watchdog_restart_strobe <= 1'b0;
            wdctl_q.timeout_write_lock <= wdctl_w.timeout_write_lock;
            if (timeout_wr) begin
                wdctl_q.watchdog_timeout_field <= wdctl_w.watchdog_timeout_field;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            flags_q <= FLAGS_RST;
            mask_q <= MASK_RST;
        end else begin
            flags_q <= flags_d;
            if (wr_mask) begin
                mask_q <= rwic_evt_t'(wbyte[2:0]);
            end
        end
    end

    // registered pin drive; one cycle behind the flags
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
            irq_pin_o_q <= 1'b0;
            irq_pin_oe_q <= 1'b0;
        end else begin
            irq_q <= irq_any;
            irq_pin_o_q <= pin_o_d;
            irq_pin_oe_q <= pin_oe_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign irq_pin_o = irq_pin_o_q;
    assign irq_pin_oe = irq_pin_oe_q;

endmodule
`default_nettype wire

// ===== hw/rwic_wdog.sv
`timescale 1ns/1ps
`default_nettype none
module rwic_wdog
    import rwic_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic restart,
    input wire logic [5:0] timeout,
    output logic expire,
    output logic [5:0] count
);
    rwic_wd_st_t st_q;
    logic [5:0] cnt_q;
    logic expire_q;
    wire logic enabled = (timeout != 6'h00);
    wire logic [5:0] cnt_inc = cnt_q + 6'h01;
    wire logic hit = tick && (cnt_inc >= timeout);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= RWIC_WD_OFF;
            cnt_q <= 6'h00;
            expire_q <= 1'b0;
        end else begin
            expire_q <= 1'b0;
            case (st_q)
                RWIC_WD_OFF: begin
                    cnt_q <= 6'h00;
                    if (enabled) begin
                        st_q <= RWIC_WD_RUN;
                    end
                end
                RWIC_WD_RUN: begin
                    if (!enabled) begin
                        st_q <= RWIC_WD_OFF;
                        cnt_q <= 6'h00;
                    end else if (restart) begin
                        cnt_q <= 6'h00;
                    end else if (hit) begin
                        cnt_q <= 6'h00;
                        expire_q <= 1'b1;
                    end else if (tick) begin
                        cnt_q <= cnt_inc;
                    end
                end
                default: begin
                    st_q <= RWIC_WD_OFF;
                    cnt_q <= 6'h00;
                end
            endcase
        end
    end

    assign expire = expire_q;
    assign count = cnt_q;
endmodule
`default_nettype wire

// ===== verification/rwic_evt_src.sv
`timescale 1ns/1ps
`default_nettype none
module rwic_evt_src (
    input wire logic mclk,
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe,
    output logic alarm_match,
    output logic power_fail,
    output logic pin_level
);
    // board pull-up, so a released open-drain line reads high
    assign pin_level = irq_pin_oe ? irq_pin_o : 1'b1;
    initial begin
        alarm_match = 1'b0;
        power_fail = 1'b0;
    end
    // one-cycle event: source 0 alarm match, else power failure
    task automatic fire(input int src);
        @(posedge mclk);
        if (src == 0) alarm_match <= 1'b1;
        else power_fail <= 1'b1;
        @(posedge mclk);
        alarm_match <= 1'b0;
        power_fail <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== verification/rwic_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rwic_top_assertions #(
    parameter int unsigned TICK_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rwic_pkg::ADDR_W-1:0] paddr,
    input wire logic [rwic_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [rwic_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic alarm_match,
    input wire logic power_fail,
    input wire logic irq,
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe
);
    import rwic_pkg::*;
    rwic_intctl_t ctl_q;
    rwic_evt_t mask_q;
    logic [5:0] fld_q;
    wire wr_done = psel && penable && pready && pwrite && pstrb[0];
    wire rd_ack = pready && !pwrite;
    wire pol = ctl_q.irq_active_high;
    wire any_en = (ctl_q.watchdog_irq_enable && mask_q.watchdog_expired_flag) ||
        (ctl_q.alarm_irq_enable && mask_q.alarm_match_flag) || (ctl_q.powerfail_irq_enable && mask_q.powerfail_flag);
    // shadow of what software wrote; the lock bit of the same word gates the field
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctl_q <= INTCTL_RST;
            mask_q <= MASK_RST;
            fld_q <= 6'h00;
        end else if (wr_done) begin
            if (paddr == ADDR_INT_CTRL) ctl_q <= pwdata[7:0];
            if (paddr == ADDR_MASK) mask_q <= pwdata[2:0];
            if (paddr == ADDR_WDOG_CTRL && !pwdata[6]) fld_q <= pwdata[5:0];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_alarm_live;
        alarm_match && ctl_q.alarm_irq_enable && mask_q.alarm_match_flag;
    endsequence
    sequence s_pf_live;
        power_fail && ctl_q.powerfail_irq_enable && mask_q.powerfail_flag;
    endsequence
    a_alarm_raises_irq: assert property (s_alarm_live |-> ##2 irq)
        else $error("alarm event did not raise irq");
    a_pf_raises_irq: assert property (s_pf_live |-> ##2 irq)
        else $error("power-fail event did not raise irq");
    a_quiet_when_off: assert property (!any_en && !$past(any_en) |-> !irq)
        else $error("irq high with every source disabled");
    a_pin_active_high: assert property (pol && $past(pol) |-> irq_pin_oe && irq_pin_o == irq)
        else $error("active-high pin does not follow irq");
    a_pin_open_drain: assert property (!pol && !$past(pol) |-> !irq_pin_o && irq_pin_oe == irq)
        else $error("open-drain pin does not follow irq");
    a_rsvd_read_zero: assert property (rd_ack && paddr == ADDR_INT_CTRL |-> prdata == {24'h0, ctl_q[7:2], 2'h0})
        else $error("interrupt control readback wrong");
    a_strobe_reads_zero: assert property (rd_ack && paddr == ADDR_WDOG_CTRL |-> !prdata[7])
        else $error("strobe bit read back as one");
    a_field_locked: assert property (rd_ack && paddr == ADDR_WDOG_CTRL |-> prdata[5:0] == fld_q)
        else $error("time-out field ignored the write lock");
endmodule
bind rwic_top rwic_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_rwic_top_assertions (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alarm_match(alarm_match), .power_fail(power_fail), .irq(irq), .irq_pin_o(irq_pin_o),
    .irq_pin_oe(irq_pin_oe));
`default_nettype wire

// ===== verification/rwic_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module rwic_top_test;
    import rwic_pkg::*;
    localparam int unsigned TICKS = 20;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic alarm_match, power_fail, irq, irq_pin_o, irq_pin_oe, pin_level;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int f, n;
    rwic_top #(.TICK_CYCLES(TICKS)) u_rwic_top (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alarm_match(alarm_match), .power_fail(power_fail), .irq(irq),
        .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));
    rwic_evt_src u_rwic_evt_src (.mclk(mclk), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
        .alarm_match(alarm_match), .power_fail(power_fail), .pin_level(pin_level));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic tally_and_finish;
        if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 && ++k < 20);
        if (k >= 20) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask
    function automatic logic [31:0] en_bit(int s);
        return (s == 0) ? 32'h40 : 32'h20;
    endfunction
    function automatic logic [31:0] flag_bit(int s);
        return (s == 0) ? 32'h2 : 32'h1;
    endfunction
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
        void'($urandom(33));
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        rdchk(ADDR_INT_CTRL, 32'hffffffff, 32'h0);
        rdchk(ADDR_WDOG_CTRL, 32'hffffffff, 32'h0);
        rdchk(ADDR_MASK, 32'hff, 32'h7);
        apb(1'b0, 20'h00100, 32'h0);
        chk_bit(err, 1'b1);
        // host keeps the reserved pair at zero; readback must show zero too
        repeat (4) begin
            f = $urandom;
            wr(ADDR_INT_CTRL, f & 32'hfc);
            rdchk(ADDR_INT_CTRL, 32'hffffffff, f & 32'hfc);
        end
        // k: 0 disabled, 1 enabled, 2 enabled but masked
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 3; k++) begin
                wr(ADDR_MASK, (k == 2) ? (32'h7 & ~flag_bit(s)) : 32'h7);
                wr(ADDR_INT_CTRL, ((k > 0) ? en_bit(s) : 32'h0) | 32'h08 | ($urandom & 32'h14));
                u_rwic_evt_src.fire(s);
                repeat (3) @(posedge mclk);
                chk_bit(irq, k == 1);
                chk_bit(pin_level, k == 1);
                rdchk(ADDR_FLAGS, 32'h7, flag_bit(s));
                wr(ADDR_FLAGS, flag_bit(s));
                repeat (2) @(posedge mclk);
                chk_bit(irq, 1'b0);
            end
        end
        wr(ADDR_MASK, 32'h7);
        wr(ADDR_INT_CTRL, 32'h40);
        u_rwic_evt_src.fire(0);
        repeat (3) @(posedge mclk);
        chk({30'h0, pin_level, irq_pin_oe}, 32'h1);
        wr(ADDR_FLAGS, 32'h2);
        repeat (2) @(posedge mclk);
        chk_bit(pin_level, 1'b1);
        // watchdog expiry time from a random field
        wr(ADDR_INT_CTRL, 32'h88);
        f = 1 + $urandom % 4;
        wr(ADDR_WDOG_CTRL, f);
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        chk_bit(n >= f * TICKS - 1 && n <= f * TICKS + 6, 1'b1);
        wr(ADDR_WDOG_CTRL, 32'hc0);
        wr(ADDR_FLAGS, 32'h4);
        wr(ADDR_WDOG_CTRL, 32'h40 | (~f & 32'h3f));
        rdchk(ADDR_WDOG_CTRL, 32'hffffffff, 32'h40 | f);
        // a strobe well inside each period keeps it from firing
        repeat (6) begin
            wr(ADDR_WDOG_CTRL, 32'hc0);
            repeat (f * TICKS / 2) @(posedge mclk);
        end
        rdchk(ADDR_FLAGS, 32'h7, 32'h0);
        wr(ADDR_INT_CTRL, 32'h08);
        repeat (f * TICKS + 10) @(posedge mclk);
        chk_bit(irq, 1'b0);
        rdchk(ADDR_FLAGS, 32'h7, 32'h4);
        wr(ADDR_WDOG_CTRL, 32'h0);
        wr(ADDR_FLAGS, 32'h4);
        repeat (300) @(posedge mclk);
        rdchk(ADDR_FLAGS, 32'h7, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
